// file: pes_engine_model.sv
// engine model: catches after a few crank cycles, stops when fuel is cut
`timescale 1ns/1ps
module pes_engine_model (
  input  wire logic clk_i,
  input  wire logic crank_i,
  input  wire logic fuel_i,
  output logic      running_o
);
  logic [1:0] spin_q;
  // slow catch so the crank output is seen to stand for several cycles
  always_ff @(posedge clk_i) begin
    if (!fuel_i) spin_q <= 2'h0;
    else if (crank_i && spin_q != 2'h3) spin_q <= spin_q + 2'h1;
  end
  assign running_o = (spin_q == 2'h3);
endmodule

// file: pes_pkg.sv
// package: constants, config and status carriers for the pump supervisor
package pes_pkg;

  // clock and one-second tick derivation
  localparam longint unsigned PES_CLK_PERIOD_PS = 64'd5000;
  localparam longint unsigned PES_SECOND_PS     = 64'd1000000000000;
  localparam int unsigned     PES_TICK_CYCLES   =
    int'(PES_SECOND_PS / PES_CLK_PERIOD_PS);

  // widths
  localparam int PES_SEC_W = 14;  // seconds, up to 9,999
  localparam int PES_VAL_W = 16;  // psi, tenths of feet, rpm
  localparam int PES_ADC_W = 10;  // raw analog count

  // start/stop source, sensed quantity, speed source
  typedef enum logic [0:0] {PES_SRC_FLOATS, PES_SRC_XDUCER} pes_src_t;
  typedef enum logic [1:0] {PES_QTY_NONE, PES_QTY_PRESSURE,
                            PES_QTY_LEVEL} pes_qty_t;
  typedef enum logic [1:0] {PES_THR_MAX_RPM, PES_THR_XDUCER,
                            PES_THR_LOCAL} pes_thr_t;

  // configuration set, held steady by the owner while the engine runs
  typedef struct packed {
    logic [PES_SEC_W-1:0] start_qualify_delay;
    logic [PES_SEC_W-1:0] pre_crank_time;
    logic [PES_SEC_W-1:0] stop_qualify_delay;
    logic [PES_SEC_W-1:0] warmup_time;
    logic [PES_SEC_W-1:0] trip_arming_timer;
    logic [PES_SEC_W-1:0] min_speed_hold_timer;
    pes_src_t             auto_run_source_select;
    pes_qty_t             sensor_quantity_select;
    pes_thr_t             speed_control_source;
    logic [PES_VAL_W-1:0] pressure_start_threshold;
    logic [PES_VAL_W-1:0] pressure_stop_threshold;
    logic [PES_VAL_W-1:0] pressure_hold_target;
    logic [PES_VAL_W-1:0] pressure_dead_zone;
    logic [PES_VAL_W-1:0] over_pressure_trip;
    logic [PES_VAL_W-1:0] under_pressure_trip;
    logic [PES_VAL_W-1:0] pressure_span_max;
    logic [PES_VAL_W-1:0] pressure_span_min;
    logic [PES_ADC_W-1:0] pressure_full_scale_count;
    logic [PES_ADC_W-1:0] pressure_zero_scale_count;
    logic [PES_VAL_W-1:0] level_start;      // tenths of a foot
    logic [PES_VAL_W-1:0] level_stop;
    logic [PES_VAL_W-1:0] level_hold_target;
    logic [PES_VAL_W-1:0] level_dead_zone;
    logic [PES_VAL_W-1:0] level_offset;
    logic [PES_VAL_W-1:0] level_span_max;
    logic [PES_VAL_W-1:0] level_span_min;
    logic [PES_ADC_W-1:0] level_full_scale_count;
    logic [PES_ADC_W-1:0] level_zero_scale_count;
    logic [PES_VAL_W-1:0] speed_floor;
    logic [PES_VAL_W-1:0] speed_ceiling;
    logic [PES_VAL_W-1:0] speed_step;
  } pes_cfg_t;

  // factory defaults, for whoever owns the settings
  localparam pes_cfg_t PES_CFG_DEFAULT = '{
    start_qualify_delay:       14'h0001,
    pre_crank_time:            14'h0001,
    stop_qualify_delay:        14'h0001,
    warmup_time:               14'h0001,
    trip_arming_timer:         14'h00B4,  // 180 s
    min_speed_hold_timer:      14'h0000,
    auto_run_source_select:    PES_SRC_FLOATS,
    sensor_quantity_select:    PES_QTY_NONE,
    speed_control_source:      PES_THR_MAX_RPM,
    pressure_start_threshold:  16'h0028,  // 40 psi
    pressure_stop_threshold:   16'h003C,  // 60 psi
    pressure_hold_target:      16'h0032,  // 50 psi
    pressure_dead_zone:        16'h0002,
    over_pressure_trip:        16'h005A,  // 90 psi
    under_pressure_trip:       16'h0019,  // 25 psi
    pressure_span_max:         16'h0064,  // 100 psi
    pressure_span_min:         16'h0000,
    pressure_full_scale_count: 10'h388,   // 904
    pressure_zero_scale_count: 10'h0B5,   // 181
    level_start:               16'h0096,  // 15.0 ft
    level_stop:                16'h0032,  // 5.0 ft
    level_hold_target:         16'h0064,  // 10.0 ft
    level_dead_zone:           16'h000A,  // 1.0 ft
    level_offset:              16'h0000,
    level_span_max:            16'h00C8,  // 20.0 ft
    level_span_min:            16'h0000,
    level_full_scale_count:    10'h388,
    level_zero_scale_count:    10'h0B5,
    speed_floor:               16'h0384,  // 900 rpm
    speed_ceiling:             16'h0640,  // 1600 rpm
    speed_step:                16'h000A
  };

  // status carrier
  typedef struct packed {
    logic shutdown;
    logic over_trip;
    logic under_trip;
    logic under_armed;
    logic fill_hold;
    logic show_pressure;
  } pes_status_t;

  localparam pes_status_t PES_STATUS_RESET = '0;

endpackage

// file: pes_scale.sv
// maps a raw analog count onto an engineering span
`timescale 1ns/1ps
module pes_scale (
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [pes_pkg::PES_ADC_W-1:0] raw_i,
  input  wire logic [pes_pkg::PES_ADC_W-1:0] full_cnt_i,
  input  wire logic [pes_pkg::PES_ADC_W-1:0] zero_cnt_i,
  input  wire logic [pes_pkg::PES_VAL_W-1:0] span_max_i,
  input  wire logic [pes_pkg::PES_VAL_W-1:0] span_min_i,
  output logic      [pes_pkg::PES_VAL_W-1:0] value_o
);
  import pes_pkg::*;

  logic [PES_VAL_W-1:0] value_d;
  logic [31:0]          num;
  logic [31:0]          den;

  // linear map; counts outside the calibration pair clamp to the span ends
  always_comb begin
    num = 32'(raw_i - zero_cnt_i) * 32'(span_max_i - span_min_i);
    den = 32'(full_cnt_i - zero_cnt_i);
    if (raw_i <= zero_cnt_i || full_cnt_i <= zero_cnt_i) begin
      value_d = span_min_i;
    end else if (raw_i >= full_cnt_i) begin
      value_d = span_max_i;
    end else begin
      value_d = span_min_i + PES_VAL_W'(num / den);
    end
  end

  // registered so the divider path ends in a flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_o <= '0;
    end else begin
      value_o <= value_d;
    end
  end
endmodule

// file: pes_tick.sv
// one-second tick generator from the system clock
`timescale 1ns/1ps
module pes_tick #(
  parameter int unsigned TICK_CYCLES = pes_pkg::PES_TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  import pes_pkg::*;

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_d;

  // free-running divider, one pulse per wrap
  always_comb begin
    tick_d = (cnt_q == 32'(TICK_CYCLES - 1));
    cnt_d  = tick_d ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule

// file: pes_top.sv
// pump engine supervisor: qualify, sequence, throttle and trip
// How it works
// - start request must persist start_qualify_delay seconds, then start begins
// - prestart output held pre_crank_time seconds before cranking
// - stop request must persist stop_qualify_delay seconds, then stop begins
// - pressure mode: start when pressure falls to pressure_start_threshold
// - pressure mode: stop when pressure rises to pressure_stop_threshold
// - pressure throttle steers speed within floor and ceiling to hold target
// - no speed change while pressure sits inside the symmetric dead zone
// - pressure governing: shut down when pressure reaches over_pressure_trip
// - pressure governing: armed shut down at under_pressure_trip
// - a zero trip limit disables that trip check
// - with pressure sensed, any enabled trip limit forces pressure on the display
// - arming timer starts at warm-up end; arms the under-pressure trip
// - hold timer starts at warm-up end; speed held at floor meanwhile
// - transducer span maps onto configured maximum and minimum values
// - full-scale raw count taken as a calibration value
// - zero-scale raw count taken as a calibration value
// - level mode: start when level reaches level_start
// - level mode: stop when level reaches level_stop
// - mounting offset added to measured level before use
// - start/stop decisions come from floats or transducer per setting
// - at load, commanded speed never exceeds speed_ceiling
`timescale 1ns/1ps
module pes_top #(
  parameter int unsigned TICK_CYCLES = pes_pkg::PES_TICK_CYCLES
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  input  wire pes_pkg::pes_cfg_t              cfg_i,
  input  wire logic [pes_pkg::PES_ADC_W-1:0] adc_count_i,
  input  wire logic                           float_start_i,
  input  wire logic                           float_stop_i,
  input  wire logic                           engine_running_i,
  input  wire logic [pes_pkg::PES_VAL_W-1:0] local_speed_i,
  output logic                                prestart_o,
  output logic                                crank_o,
  output logic                                fuel_run_o,
  output logic      [pes_pkg::PES_VAL_W-1:0] speed_cmd_o,
  output logic      [pes_pkg::PES_VAL_W-1:0] display_value_o,
  output pes_pkg::pes_status_t                status_o
);
  import pes_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_PRESTART, S_CRANK, S_WARMUP,
                            S_AT_LOAD, S_STOPPING, S_SHUTDOWN} pes_state_t;

  // clamp a speed into the configured floor and ceiling
  function automatic logic [PES_VAL_W-1:0] clamp_speed(
    input logic [PES_VAL_W:0]   v,
    input logic [PES_VAL_W-1:0] lo,
    input logic [PES_VAL_W-1:0] hi);
    if (v > {1'b0, hi}) begin
      clamp_speed = hi;
    end else if (v < {1'b0, lo}) begin
      clamp_speed = lo;
    end else begin
      clamp_speed = v[PES_VAL_W-1:0];
    end
  endfunction

  // a count of elapsed seconds has reached its setting on this tick
  function automatic logic secs_done(input logic [PES_SEC_W-1:0] cnt,
                                     input logic [PES_SEC_W-1:0] lim);
    secs_done = ({1'b0, cnt} + 15'h0001) >= {1'b0, lim};
  endfunction

  logic                 tick;
  logic [PES_VAL_W-1:0] scaled;
  logic [PES_ADC_W-1:0] full_cnt;
  logic [PES_ADC_W-1:0] zero_cnt;
  logic [PES_VAL_W-1:0] span_max;
  logic [PES_VAL_W-1:0] span_min;

  // one-second time base for every delay
  pes_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_o  (tick)
  );

  // calibration pair and span follow the sensed quantity
  always_comb begin
    if (cfg_i.sensor_quantity_select == PES_QTY_LEVEL) begin
      full_cnt = cfg_i.level_full_scale_count;
      zero_cnt = cfg_i.level_zero_scale_count;
      span_max = cfg_i.level_span_max;
      span_min = cfg_i.level_span_min;
    end else begin
      full_cnt = cfg_i.pressure_full_scale_count;
      zero_cnt = cfg_i.pressure_zero_scale_count;
      span_max = cfg_i.pressure_span_max;
      span_min = cfg_i.pressure_span_min;
    end
  end

  pes_scale u_scale (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .raw_i      (adc_count_i),
    .full_cnt_i (full_cnt),
    .zero_cnt_i (zero_cnt),
    .span_max_i (span_max),
    .span_min_i (span_min),
    .value_o    (scaled)
  );

  // measured quantities and the decisions drawn from them
  logic [PES_VAL_W:0]   lvl_sum;
  logic [PES_VAL_W-1:0] level;
  logic [PES_VAL_W-1:0] psi;
  logic                 is_psi;
  logic                 is_lvl;
  logic                 psi_governs;
  logic                 want_start;
  logic                 want_stop;
  logic                 over_now;
  logic                 under_now;
  logic                 below_band;
  logic                 above_band;

  always_comb begin
    lvl_sum = {1'b0, scaled} + {1'b0, cfg_i.level_offset};
    level   = lvl_sum[PES_VAL_W] ? '1 : lvl_sum[PES_VAL_W-1:0];
    psi     = scaled;
    is_psi  = cfg_i.sensor_quantity_select == PES_QTY_PRESSURE;
    is_lvl  = cfg_i.sensor_quantity_select == PES_QTY_LEVEL;
    psi_governs = is_psi &&
      (cfg_i.auto_run_source_select == PES_SRC_XDUCER ||
       cfg_i.speed_control_source == PES_THR_XDUCER);
    // floats or transducer, never both
    if (cfg_i.auto_run_source_select == PES_SRC_FLOATS) begin
      want_start = float_start_i;
      want_stop  = float_stop_i;
    end else begin
      want_start = (is_psi && psi <= cfg_i.pressure_start_threshold)
                || (is_lvl && level >= cfg_i.level_start);
      want_stop  = (is_psi && psi >= cfg_i.pressure_stop_threshold)
                || (is_lvl && level <= cfg_i.level_stop);
    end
    // a zero limit switches its check off
    over_now  = psi_governs && cfg_i.over_pressure_trip != '0 &&
                psi >= cfg_i.over_pressure_trip;
    under_now = psi_governs && cfg_i.under_pressure_trip != '0 &&
                psi <= cfg_i.under_pressure_trip;
    // pressure low means more speed; level high means more speed (empty)
    if (is_lvl) begin
      above_band = {1'b0, level} + {1'b0, cfg_i.level_dead_zone}
                   < {1'b0, cfg_i.level_hold_target};
      below_band = {1'b0, level} > {1'b0, cfg_i.level_hold_target}
                   + {1'b0, cfg_i.level_dead_zone};
    end else begin
      below_band = {1'b0, psi} + {1'b0, cfg_i.pressure_dead_zone}
                   < {1'b0, cfg_i.pressure_hold_target};
      above_band = {1'b0, psi} > {1'b0, cfg_i.pressure_hold_target}
                   + {1'b0, cfg_i.pressure_dead_zone};
    end
  end

  // sequencer state and timers
  pes_state_t           st_q, st_d;
  logic [PES_SEC_W-1:0] start_cnt_q, start_cnt_d;
  logic [PES_SEC_W-1:0] stop_cnt_q, stop_cnt_d;
  logic [PES_SEC_W-1:0] seq_cnt_q, seq_cnt_d;
  logic [PES_SEC_W-1:0] arm_cnt_q, arm_cnt_d;
  logic [PES_SEC_W-1:0] fill_cnt_q, fill_cnt_d;
  logic                 armed_q, armed_d;
  logic                 fill_q, fill_d;
  logic                 over_q, over_d;
  logic                 under_q, under_d;
  logic [PES_VAL_W-1:0] speed_q, speed_d;
  logic                 running;
  logic                 trip;

  always_comb begin
    st_d        = st_q;
    start_cnt_d = start_cnt_q;
    stop_cnt_d  = stop_cnt_q;
    seq_cnt_d   = seq_cnt_q;
    arm_cnt_d   = arm_cnt_q;
    fill_cnt_d  = fill_cnt_q;
    armed_d     = armed_q;
    fill_d      = fill_q;
    over_d      = over_q;
    under_d     = under_q;
    speed_d     = speed_q;
    running     = st_q == S_WARMUP || st_q == S_AT_LOAD;
    trip        = running && (over_now || (armed_q && under_now));

    // qualify counters restart whenever their request drops
    if (!want_start) begin
      start_cnt_d = '0;
    end else if (tick && !secs_done(start_cnt_q, cfg_i.start_qualify_delay))
    begin
      start_cnt_d = start_cnt_q + 14'h0001;
    end
    if (!want_stop) begin
      stop_cnt_d = '0;
    end else if (tick && !secs_done(stop_cnt_q, cfg_i.stop_qualify_delay))
    begin
      stop_cnt_d = stop_cnt_q + 14'h0001;
    end
    if (tick) begin
      seq_cnt_d = seq_cnt_q + 14'h0001;
    end

    case (st_q)
      S_IDLE: begin
        speed_d = cfg_i.speed_floor;
        armed_d = 1'b0;
        fill_d  = 1'b0;
        if (want_start && tick &&
            secs_done(start_cnt_q, cfg_i.start_qualify_delay)) begin
          st_d      = S_PRESTART;
          seq_cnt_d = '0;
        end
      end
      S_PRESTART: begin
        if (tick && secs_done(seq_cnt_q, cfg_i.pre_crank_time)) begin
          st_d = S_CRANK;
        end
      end
      S_CRANK: begin
        if (engine_running_i) begin
          st_d      = S_WARMUP;
          seq_cnt_d = '0;
        end
      end
      S_WARMUP: begin
        if (tick && secs_done(seq_cnt_q, cfg_i.warmup_time)) begin
          st_d       = S_AT_LOAD;
          arm_cnt_d  = '0;
          fill_cnt_d = '0;
          armed_d    = cfg_i.trip_arming_timer == '0;
          fill_d     = cfg_i.min_speed_hold_timer != '0;
        end
      end
      S_AT_LOAD: begin
        // arming and hold timers run side by side from warm-up end
        if (tick && !armed_q) begin
          arm_cnt_d = arm_cnt_q + 14'h0001;
          armed_d   = secs_done(arm_cnt_q, cfg_i.trip_arming_timer);
        end
        if (tick && fill_q) begin
          fill_cnt_d = fill_cnt_q + 14'h0001;
          fill_d = !secs_done(fill_cnt_q, cfg_i.min_speed_hold_timer);
        end
        if (fill_q) begin
          speed_d = cfg_i.speed_floor;
        end else begin
          case (cfg_i.speed_control_source)
            PES_THR_XDUCER: begin
              // one step a second gives the loop time to settle
              if (tick && below_band) begin
                speed_d = clamp_speed({1'b0, speed_q} + {1'b0,
                  cfg_i.speed_step}, cfg_i.speed_floor,
                  cfg_i.speed_ceiling);
              end else if (tick && above_band) begin
                speed_d = clamp_speed(speed_q > cfg_i.speed_step ?
                  {1'b0, speed_q} - {1'b0, cfg_i.speed_step} : '0,
                  cfg_i.speed_floor, cfg_i.speed_ceiling);
              end
            end
            PES_THR_LOCAL: begin
              speed_d = clamp_speed({1'b0, local_speed_i},
                cfg_i.speed_floor, cfg_i.speed_ceiling);
            end
            default: begin
              speed_d = cfg_i.speed_ceiling;
            end
          endcase
        end
        if (want_stop && tick &&
            secs_done(stop_cnt_q, cfg_i.stop_qualify_delay)) begin
          st_d = S_STOPPING;
        end
      end
      S_STOPPING: begin
        speed_d = cfg_i.speed_floor;
        if (!engine_running_i) begin
          st_d = S_IDLE;
        end
      end
      S_SHUTDOWN: begin
        speed_d = cfg_i.speed_floor;
      end
      default: begin
        st_d = S_SHUTDOWN;
      end
    endcase

    // trips win over every other move and latch until reset
    if (trip) begin
      st_d    = S_SHUTDOWN;
      over_d  = over_q | over_now;
      under_d = under_q | (armed_q && under_now);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q        <= S_IDLE;
      start_cnt_q <= '0;
      stop_cnt_q  <= '0;
      seq_cnt_q   <= '0;
      arm_cnt_q   <= '0;
      fill_cnt_q  <= '0;
      armed_q     <= 1'b0;
      fill_q      <= 1'b0;
      over_q      <= 1'b0;
      under_q     <= 1'b0;
      speed_q     <= '0;
    end else begin
      st_q        <= st_d;
      start_cnt_q <= start_cnt_d;
      stop_cnt_q  <= stop_cnt_d;
      seq_cnt_q   <= seq_cnt_d;
      arm_cnt_q   <= arm_cnt_d;
      fill_cnt_q  <= fill_cnt_d;
      armed_q     <= armed_d;
      fill_q      <= fill_d;
      over_q      <= over_d;
      under_q     <= under_d;
      speed_q     <= speed_d;
    end
  end

  // output flops, decoded from the next state so they track st_q
  pes_status_t          status_d;
  logic [PES_VAL_W-1:0] disp_d;

  always_comb begin
    status_d.shutdown      = st_d == S_SHUTDOWN;
    status_d.over_trip     = over_d;
    status_d.under_trip    = under_d;
    status_d.under_armed   = armed_d;
    status_d.fill_hold     = fill_d;
    status_d.show_pressure = is_psi && (psi_governs ||
      cfg_i.over_pressure_trip != '0 ||
      cfg_i.under_pressure_trip != '0);
    disp_d = is_lvl ? level : scaled;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prestart_o      <= 1'b0;
      crank_o         <= 1'b0;
      fuel_run_o      <= 1'b0;
      speed_cmd_o     <= '0;
      display_value_o <= '0;
      status_o        <= PES_STATUS_RESET;
    end else begin
      prestart_o      <= st_d == S_PRESTART;
      crank_o         <= st_d == S_CRANK;
      fuel_run_o      <= st_d == S_CRANK || st_d == S_WARMUP ||
                         st_d == S_AT_LOAD;
      speed_cmd_o     <= speed_d;
      display_value_o <= disp_d;
      status_o        <= status_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_start_taken;
    st_q == S_IDLE ##1 st_q == S_PRESTART;
  endsequence

  a_start_qualify: assert property (
    seq_start_taken |-> $past(tick) && $past(want_start) &&
      ($past(start_cnt_q) + 14'h0001 >= $past(cfg_i.start_qualify_delay)))
    else $error("start taken before qualify delay");
  a_prestart_out: assert property (
    seq_start_taken |-> prestart_o && !crank_o)
    else $error("prestart output missing after start");
  a_stop_qualify: assert property (
    st_q == S_AT_LOAD ##1 st_q == S_STOPPING |-> $past(tick) &&
      ($past(stop_cnt_q) + 14'h0001 >= $past(cfg_i.stop_qualify_delay)))
    else $error("stop taken before qualify delay");
  a_over_trip: assert property (
    running && over_now |=> st_q == S_SHUTDOWN && status_o.over_trip)
    else $error("over-pressure did not shut down");
  a_under_armed: assert property (
    $rose(status_o.under_trip) |-> $past(armed_q))
    else $error("under-pressure trip while unarmed");
  a_zero_disables: assert property (
    $rose(status_o.over_trip) |-> $past(cfg_i.over_pressure_trip) != '0)
    else $error("zero limit still trips");
  a_speed_ceiling: assert property (
    st_q == S_AT_LOAD |=> speed_cmd_o <= $past(cfg_i.speed_ceiling))
    else $error("speed above ceiling at load");
  a_fill_floor: assert property (
    st_q == S_AT_LOAD && fill_q |=> speed_cmd_o == $past(cfg_i.speed_floor))
    else $error("speed not held at floor");
  a_dead_zone: assert property (
    st_q == S_AT_LOAD && !fill_q && !below_band && !above_band &&
    cfg_i.speed_control_source == PES_THR_XDUCER && $stable(speed_q)
    |=> speed_q == $past(speed_q))
    else $error("speed moved inside dead zone");
  a_shutdown_latch: assert property (
    st_q == S_SHUTDOWN |=> (st_q == S_SHUTDOWN && !fuel_run_o) [*4])
    else $error("shutdown released without reset");
endmodule

// file: test_pes_top.sv
// self-checking bench for the pump engine supervisor
`timescale 1ns/1ps
module test_pes_top;
  import pes_pkg::*;
  localparam int TK = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic run, pre, crk, fuel;
  logic fs = 1'b0, fp = 1'b0;
  logic [PES_VAL_W-1:0] ls = 16'h0000;
  logic [PES_ADC_W-1:0] adc = 10'h032;
  logic [PES_VAL_W-1:0] spd, disp, v;
  pes_cfg_t cfg = PES_CFG_DEFAULT, c2;
  pes_status_t st;
  int mismatches = 0, total_checks = 0, cyc = 0, n;
  logic [31:0] rng = 32'h0001_4883;
  always #2.5 clk_i = ~clk_i;
  pes_top #(.TICK_CYCLES(TK)) i_pes_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cfg_i(cfg), .adc_count_i(adc), .float_start_i(fs),
    .float_stop_i(fp), .engine_running_i(run), .local_speed_i(ls),
    .prestart_o(pre), .crank_o(crk), .fuel_run_o(fuel), .speed_cmd_o(spd),
    .display_value_o(disp), .status_o(st));
  pes_engine_model i_pes_engine_model (.clk_i(clk_i), .crank_i(crk),
    .fuel_i(fuel), .running_o(run));
  // xorshift source, fixed seed so a failure can be replayed
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // unit span over a 0..100 count window, clamped above full scale
  function automatic logic [15:0] exp_psi(input logic [9:0] r);
    return (r >= 10'h064) ? 16'h0064 : {6'h00, r};
  endfunction
  task automatic cmp_val(input logic [15:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic cmp_bit(input logic g, e, input string m);
    cmp_val({15'h0000, g}, {15'h0000, e}, m);
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, well beyond the hundred-odd cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    cfg.auto_run_source_select = PES_SRC_XDUCER;
    cfg.sensor_quantity_select = PES_QTY_PRESSURE;
    cfg.speed_control_source = PES_THR_XDUCER;
    cfg.pressure_full_scale_count = 10'h064;
    cfg.pressure_zero_scale_count = 10'h000;
    cfg.pre_crank_time = 14'h0002;
    cfg.trip_arming_timer = 14'h0002;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    cmp_val(spd, cfg.speed_floor, "floor after reset");
    // random counts kept above the start threshold so idle stays idle
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      @(posedge clk_i);
      adc <= 10'h029 + 10'(rng % 80);
      repeat (3) @(negedge clk_i);
      cmp_val(disp, exp_psi(adc), "scaled pressure");
    end
    $display("scaling test done");
    @(posedge clk_i);
    adc <= 10'h028; // exactly at the start threshold
    @(posedge clk_i iff pre === 1'b1);
    n = 0;
    while (pre === 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    cmp_val(16'(n), 16'(2 * TK), "prestart length");
    cmp_bit(crk, 1'b1, "crank after prestart");
    @(posedge clk_i iff run === 1'b1);
    repeat (3 * TK) @(negedge clk_i);
    v = spd;
    repeat (TK) @(negedge clk_i);
    cmp_val(spd, v + cfg.speed_step, "speed step up");
    cmp_bit(st.under_armed, 1'b1, "under trip armed");
    cmp_bit(st.show_pressure, 1'b1, "pressure shown");
    cmp_bit(st.fill_hold, 1'b0, "no hold with zero timer");
    $display("start test done");
    // pressure back on target: speed must rest inside the dead zone
    @(posedge clk_i);
    adc <= 10'h032;
    repeat (3) @(negedge clk_i);
    v = spd;
    repeat (2 * TK) @(negedge clk_i);
    cmp_val(spd, v, "speed held in dead zone");
    @(posedge clk_i);
    adc <= 10'h05A;
    repeat (5) @(negedge clk_i);
    cmp_bit(st.shutdown, 1'b1, "shutdown on over trip");
    cmp_bit(st.over_trip, 1'b1, "over trip flag");
    cmp_bit(fuel, 1'b0, "fuel cut on trip");
    cmp_bit(st.under_trip, 1'b0, "no under trip");
    $display("trip test done");
    // mid-run reset, then floats with level sensing and local throttle
    c2 = cfg;
    c2.auto_run_source_select = PES_SRC_FLOATS;
    c2.sensor_quantity_select = PES_QTY_LEVEL;
    c2.speed_control_source = PES_THR_LOCAL;
    c2.min_speed_hold_timer = 14'h0002;
    c2.level_full_scale_count = 10'h064;
    c2.level_zero_scale_count = 10'h000;
    c2.level_span_max = 16'h0064;
    c2.level_offset = 16'h000A;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    cfg <= c2;
    adc <= 10'h032;
    ls <= 16'h07D0; // above the ceiling, so the clamp must bite
    fs <= 1'b1; // float start held through the release
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    cmp_bit(st.shutdown, 1'b0, "shutdown cleared by reset");
    cmp_val(spd, cfg.speed_floor, "floor after second reset");
    @(posedge clk_i iff run === 1'b1);
    repeat (2 * TK) @(negedge clk_i);
    cmp_bit(st.fill_hold, 1'b1, "hold timer running");
    cmp_val(spd, cfg.speed_floor, "floor while holding");
    cmp_val(disp, {6'h00, adc} + cfg.level_offset, "level offset");
    repeat (2 * TK) @(negedge clk_i);
    cmp_val(spd, cfg.speed_ceiling, "local speed clamped");
    @(posedge clk_i);
    fs <= 1'b0;
    fp <= 1'b1;
    repeat (TK + 3) @(negedge clk_i);
    cmp_bit(fuel, 1'b0, "fuel cut after stop");
    cmp_val(spd, cfg.speed_floor, "floor after stop");
    cmp_bit(st.shutdown, 1'b0, "stop is no shutdown");
    $display("float and level test done");
    final_report();
  end
endmodule
